// ### shared/i2cm_pkg.sv
// Purpose : constants and types for the i2c master that drives the
//           uart bridge register port
// Assumes : 125 MHz system clock, fast-mode bus
// Notes   : pins are open drain, oe high pulls the line low
package i2cm_pkg;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int SYS_CLK_NS = 8;
  localparam int I2C_BIT_NS = 2500;
  // a bit is four quarters; least time, so round up
  localparam int QTR_CYC    = (I2C_BIT_NS + 4 * SYS_CLK_NS - 1)
                              / (4 * SYS_CLK_NS);

  // ****************************************************
  // address and subaddress layout
  // ****************************************************
  localparam logic [7:0] SLAVE_BASE   = 8'h90;
  localparam int         STRAP_UP_POS = 3;
  localparam int         STRAP_LO_POS = 1;
  localparam int         SUB_REG_POS  = 3;
  localparam int         SUB_CH_POS   = 1;
  localparam logic [1:0] CHANNEL_SEL  = 2'h0;
  localparam logic       DIR_WRITE    = 1'h0;
  localparam logic       DIR_READ     = 1'h1;
  localparam int         BYTE_BITS    = 8;

  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [2:0] {
    I2CM_IDLE, I2CM_START, I2CM_BIT, I2CM_WAITD, I2CM_STOP
  } i2cm_state_t;

  typedef enum logic [2:0] {
    I2CM_ADDRW, I2CM_SUB, I2CM_WR, I2CM_ADDRR, I2CM_RD
  } i2cm_phase_t;

  typedef struct packed {
    logic       read;
    logic [3:0] reg_sel;
    logic [7:0] count;
  } i2cm_cmd_t;

  typedef struct packed {
    logic scl_i;
    logic sda_i;
  } i2cm_pin_in_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } i2cm_pin_out_t;

endpackage : i2cm_pkg

// ### src/i2cm_top.sv
// Purpose : i2c bus master issuing register writes and reads to the
//           uart bridge slave port
// Assumes : single master on the bus; pull-ups outside
// Notes   : scl is made here from sys_clk; slave stretching is honoured
`timescale 1ns/10ps

// Overview of operation
// - start is sda falling with scl high, stop is sda rising with scl high
// - only this master makes start and stop; the slave never does
// - sda changes only while scl is low, except for start and stop
// - each byte is eight bits msb first followed by an acknowledge bit
// - master supplies the scl pulse for every acknowledge bit
// - transmitter releases sda on ack clock; acknowledging receiver pulls low
// - master reader acks every byte but the last, which it nacks
// - first byte holds seven address bits and a direction bit in bit 0
// - byte after address is an acknowledged subaddress without direction
// - subaddress: bits 6:3 register, bits 2:1 channel sent as 00
// - write: start, address write, subaddress, data bytes, stop
// - read: address, subaddress, repeated start, address read, data, stop
module i2cm_top #(
  parameter int QTR = i2cm_pkg::QTR_CYC
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic [1:0]              addr_strap_upper,
  input  wire logic [1:0]              addr_strap_lower,
  input  wire i2cm_pkg::i2cm_cmd_t     cmd,
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  input  wire logic [7:0]              wr_data,
  input  wire logic                    wr_valid,
  output logic                         wr_ready,
  output logic [7:0]                   rd_data,
  output logic                         rd_valid,
  output logic                         done,
  output logic                         nack_err,
  output logic                         busy,
  input  wire i2cm_pkg::i2cm_pin_in_t  pin_i,
  output i2cm_pkg::i2cm_pin_out_t      pin_o
);

  // refuse a quarter that the 16-bit divider cannot count
  if (QTR < 2 || QTR > 65535)
  begin : g_qtr_check
    $error("QTR must lie in 2..65535");
  end

  // ****************************************************
  // address byte from the strap codes
  // ****************************************************
  function automatic logic [7:0] addr_byte(input logic [1:0] up,
                                           input logic [1:0] lo,
                                           input logic       dir);
    logic [7:0] a;
    a = i2cm_pkg::SLAVE_BASE
      + (8'(up) << i2cm_pkg::STRAP_UP_POS)
      + (8'(lo) << i2cm_pkg::STRAP_LO_POS);
    addr_byte = {a[7:1], dir};
  endfunction : addr_byte

  typedef struct packed {
    i2cm_pkg::i2cm_state_t state;
    i2cm_pkg::i2cm_phase_t phase;
    logic [15:0]           cnt;
    logic [1:0]            qtr;
    logic [3:0]            bitn;
    logic [7:0]            shreg;
    logic [7:0]            remain;
    logic                  read;
    logic [3:0]            reg_sel;
    logic [1:0]            up;
    logic [1:0]            lo;
    logic                  acked;
    logic                  sda_m;
    logic                  sda_s;
    logic                  scl_m;
    logic                  scl_s;
    logic                  cmd_ready;
    logic                  wr_ready;
    logic [7:0]            rd_data;
    logic                  rd_valid;
    logic                  done;
    logic                  nack_err;
    logic                  busy;
    i2cm_pkg::i2cm_pin_out_t pins;
  } i2cm_st_t;

  i2cm_st_t st_reg;
  i2cm_st_t st_next;

  // ****************************************************
  // next state
  // ****************************************************
  always_comb
  begin
    logic tick;
    logic hold;
    logic nak;
    tick = 1'b0;
    hold = 1'b0;
    nak  = 1'b0;
    st_next          = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.done     = 1'b0;
    // the first stage feeds only the second
    st_next.sda_m = pin_i.sda_i;
    st_next.sda_s = st_reg.sda_m;
    st_next.scl_m = pin_i.scl_i;
    st_next.scl_s = st_reg.scl_m;
    tick = (st_reg.cnt == 16'(QTR - 1));
    st_next.cnt = tick ? 16'h0000 : st_reg.cnt + 16'h0001;

    case (st_reg.state)
      i2cm_pkg::I2CM_IDLE:
      begin
        st_next.cmd_ready = 1'b1;
        if (cmd_valid && st_reg.cmd_ready)
        begin
          st_next.cmd_ready = 1'b0;
          st_next.busy      = 1'b1;
          st_next.nack_err  = 1'b0;
          st_next.read      = cmd.read;
          st_next.reg_sel   = cmd.reg_sel;
          st_next.remain    = cmd.count;
          st_next.up        = addr_strap_upper;
          st_next.lo        = addr_strap_lower;
          st_next.phase     = i2cm_pkg::I2CM_ADDRW;
          st_next.state     = i2cm_pkg::I2CM_START;
          st_next.qtr       = 2'h0;
          st_next.cnt       = 16'h0000;
        end
      end

      i2cm_pkg::I2CM_START:
      begin
        if (tick)
        begin
          case (st_reg.qtr)
            2'h0: st_next.pins.sda_oe = 1'b0;
            2'h1: st_next.pins.scl_oe = 1'b0;
            2'h2:
            begin
              hold = !st_reg.scl_s;
              // sda falls with scl high: start
              if (!hold)
                st_next.pins.sda_oe = 1'b1;
            end
            default:
            begin
              st_next.pins.scl_oe = 1'b1;
              st_next.state = i2cm_pkg::I2CM_BIT;
              st_next.bitn  = 4'h0;
              st_next.shreg = addr_byte(st_reg.up, st_reg.lo,
                (st_reg.phase == i2cm_pkg::I2CM_ADDRR) ?
                i2cm_pkg::DIR_READ : i2cm_pkg::DIR_WRITE);
            end
          endcase
        end
      end

      i2cm_pkg::I2CM_BIT:
      begin
        if (tick)
        begin
          case (st_reg.qtr)
            2'h0:
            begin
              // data set up only while scl is low
              if (st_reg.bitn < 4'(i2cm_pkg::BYTE_BITS))
                st_next.pins.sda_oe = (st_reg.phase != i2cm_pkg::I2CM_RD)
                                      && !st_reg.shreg[7];
              else if (st_reg.phase == i2cm_pkg::I2CM_RD)
                st_next.pins.sda_oe = (st_reg.remain > 8'h01);
              else
                st_next.pins.sda_oe = 1'b0;
            end
            2'h1: st_next.pins.scl_oe = 1'b0;
            2'h2:
            begin
              hold = !st_reg.scl_s;
              if (!hold && st_reg.bitn < 4'(i2cm_pkg::BYTE_BITS))
                st_next.shreg = {st_reg.shreg[6:0], st_reg.sda_s};
              else if (!hold)
                st_next.acked = !st_reg.sda_s;
            end
            default:
            begin
              st_next.pins.scl_oe = 1'b1;
              if (st_reg.bitn < 4'(i2cm_pkg::BYTE_BITS))
                st_next.bitn = st_reg.bitn + 4'h1;
              else
              begin
                st_next.bitn = 4'h0;
                // a missing slave ack ends the transfer
                nak = !st_reg.acked && (st_reg.phase != i2cm_pkg::I2CM_RD);
                if (nak)
                begin
                  st_next.nack_err = 1'b1;
                  st_next.state    = i2cm_pkg::I2CM_STOP;
                end
                else
                begin
                  case (st_reg.phase)
                    i2cm_pkg::I2CM_ADDRW:
                    begin
                      st_next.phase = i2cm_pkg::I2CM_SUB;
                      st_next.shreg = {1'b0, st_reg.reg_sel, 3'h0}
                        | {5'h00, i2cm_pkg::CHANNEL_SEL, 1'b0};
                    end
                    i2cm_pkg::I2CM_SUB:
                    begin
                      if (st_reg.read)
                      begin
                        // turn direction with a repeated start
                        st_next.phase = i2cm_pkg::I2CM_ADDRR;
                        st_next.state = i2cm_pkg::I2CM_START;
                      end
                      else if (st_reg.remain == 8'h00)
                        st_next.state = i2cm_pkg::I2CM_STOP;
                      else
                      begin
                        st_next.phase = i2cm_pkg::I2CM_WR;
                        st_next.state = i2cm_pkg::I2CM_WAITD;
                      end
                    end
                    i2cm_pkg::I2CM_WR:
                    begin
                      st_next.remain = st_reg.remain - 8'h01;
                      if (st_reg.remain <= 8'h01)
                        st_next.state = i2cm_pkg::I2CM_STOP;
                      else
                        st_next.state = i2cm_pkg::I2CM_WAITD;
                    end
                    i2cm_pkg::I2CM_ADDRR:
                    begin
                      st_next.phase = i2cm_pkg::I2CM_RD;
                      st_next.shreg = 8'hff;
                    end
                    default:
                    begin
                      st_next.rd_data  = st_reg.shreg;
                      st_next.rd_valid = 1'b1;
                      st_next.remain   = st_reg.remain - 8'h01;
                      if (st_reg.remain <= 8'h01)
                        st_next.state = i2cm_pkg::I2CM_STOP;
                    end
                  endcase
                end
              end
            end
          endcase
        end
      end

      i2cm_pkg::I2CM_WAITD:
      begin
        // scl stays low while the user has no byte ready
        st_next.wr_ready = 1'b1;
        if (st_reg.wr_ready && wr_valid)
        begin
          st_next.wr_ready = 1'b0;
          st_next.shreg    = wr_data;
          st_next.state    = i2cm_pkg::I2CM_BIT;
          st_next.qtr      = 2'h0;
          st_next.cnt      = 16'h0000;
        end
      end

      default:
      begin
        if (tick)
        begin
          case (st_reg.qtr)
            2'h0: st_next.pins.sda_oe = 1'b1;
            2'h1: st_next.pins.scl_oe = 1'b0;
            2'h2:
            begin
              hold = !st_reg.scl_s;
              // sda rises with scl high: stop
              if (!hold)
                st_next.pins.sda_oe = 1'b0;
            end
            default:
            begin
              st_next.done  = 1'b1;
              st_next.busy  = 1'b0;
              st_next.state = i2cm_pkg::I2CM_IDLE;
            end
          endcase
        end
      end
    endcase

    if (tick && !hold && st_reg.state != i2cm_pkg::I2CM_IDLE
        && st_reg.state != i2cm_pkg::I2CM_WAITD)
      st_next.qtr = st_reg.qtr + 2'h1;
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_reg        <= '0;
      st_reg.state  <= i2cm_pkg::I2CM_IDLE;
      st_reg.phase  <= i2cm_pkg::I2CM_ADDRW;
      st_reg.sda_m  <= 1'b1;
      st_reg.sda_s  <= 1'b1;
      st_reg.scl_m  <= 1'b1;
      st_reg.scl_s  <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign cmd_ready = st_reg.cmd_ready;
  assign wr_ready  = st_reg.wr_ready;
  assign rd_data   = st_reg.rd_data;
  assign rd_valid  = st_reg.rd_valid;
  assign done      = st_reg.done;
  assign nack_err  = st_reg.nack_err;
  assign busy      = st_reg.busy;
  assign pin_o     = st_reg.pins;

endmodule : i2cm_top

// ### tb/i2cm_checker.sv
// Purpose : bus and handshake checks on the i2c register master
// Assumes : bound to the top module, sees only its ports
// Notes   : bit count restarts at each start condition
`timescale 1ns/10ps
module i2cm_checker #(
  parameter int QTR = 4
) (
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  input wire i2cm_pkg::i2cm_cmd_t     cmd,
  input wire logic                    cmd_valid,
  input wire logic                    cmd_ready,
  input wire logic                    busy,
  input wire logic                    done,
  input wire logic                    nack_err,
  input wire logic                    rd_valid,
  input wire logic                    wr_valid,
  input wire logic                    wr_ready,
  input wire i2cm_pkg::i2cm_pin_out_t pin_o
);
  // ********************
  // helpers
  // ********************
  localparam int WAIT_MAX = 4 * QTR + 8;
  logic [3:0] bcnt_reg;
  logic       rd_reg;
  logic       scl_q_reg;
  logic       sda_q_reg;
  wire start_w = pin_o.sda_oe && !sda_q_reg && !pin_o.scl_oe;
  wire stop_w  = !pin_o.sda_oe && sda_q_reg && !pin_o.scl_oe;
  wire rel_w   = !pin_o.scl_oe && scl_q_reg;
  // scl releases since start: nine per byte, one more for a stop
  always_ff @(posedge sys_clk)
    if (!rst_n)
      {bcnt_reg, rd_reg, scl_q_reg, sda_q_reg} <= 7'h00;
    else
    begin
      scl_q_reg <= pin_o.scl_oe;
      sda_q_reg <= pin_o.sda_oe;
      if (cmd_valid && cmd_ready)
        rd_reg <= cmd.read;
      if (start_w)
        bcnt_reg <= 4'h0;
      else if (rel_w)
        bcnt_reg <= (bcnt_reg == 4'h8) ? 4'h0 : bcnt_reg + 4'h1;
    end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence start_s; start_w; endsequence
  sequence stop_s; stop_w; endsequence
  sequence ack_clk_s; rel_w && bcnt_reg == 4'h8; endsequence
  chk_idle_free: assert property (
    !busy |-> !pin_o.scl_oe && !pin_o.sda_oe) else $error("held idle");
  chk_drive_zero: assert property (
    1'b1 |-> !pin_o.scl_o && !pin_o.sda_o) else $error("pin driven high");
  chk_start_first: assert property (
    $rose(busy) |-> !pin_o.scl_oe throughout (##[0:WAIT_MAX] start_s))
    else $error("no start");
  chk_stop_done: assert property (
    stop_s |-> ##[0:WAIT_MAX] done) else $error("stop without done");
  chk_stop_frame: assert property (
    stop_s |-> bcnt_reg == 4'h1) else $error("stop inside a byte");
  chk_ack_free: assert property (
    ack_clk_s ##0 !rd_reg |-> !pin_o.sda_oe) else $error("sda held at ack");
  chk_sda_quiet: assert property (
    $changed(pin_o.sda_oe) && !pin_o.scl_oe |-> bcnt_reg <= 4'h1)
    else $error("sda moved with scl high");
  chk_take_busy: assert property (
    cmd_valid && cmd_ready |=> busy && !cmd_ready && !nack_err)
    else $error("take not seen");
  chk_done_ready: assert property (
    done |-> !busy ##1 cmd_ready) else $error("ready not back");
  chk_read_pulse: assert property (
    rd_valid |-> rd_reg && busy ##1 !rd_valid) else $error("bad read pulse");
  chk_data_take: assert property (
    wr_ready && wr_valid |=> !wr_ready && busy) else $error("byte not taken");
  chk_data_wait: assert property (
    wr_ready && !wr_valid |=> wr_ready && busy) else $error("slot dropped");
endmodule : i2cm_checker

// ### tb/i2cm_slave.sv
// Purpose : behavioural register port slave on the i2c bus
// Assumes : wired-and lines with pull-ups outside
// Notes   : never stretches scl; reads walk up from the subaddress
`timescale 1ns/10ps
module i2cm_slave (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [1:0] strap_up,
  input  wire logic [1:0] strap_lo,
  input  wire logic       nack_data,
  output logic            sda_oe
);
  // ********************
  // bus side
  // ********************
  logic [7:0] mem [16];
  logic [7:0] wlog [$];
  logic [7:0] sh, tx, last_sub;
  logic [3:0] ptr;
  logic       mack;
  int         bitn;
  int         ph;
  wire  [7:0] own = 8'h90 + {3'h0, strap_up, 3'h0}
                  + {5'h0, strap_lo, 1'h0};
  initial sda_oe = 1'b0;
  always @(negedge sda)
    if (scl)
    begin
      ph     = 1;
      bitn   = 0;
      sda_oe = 1'b0;
    end
  always @(posedge sda)
    if (scl)
      ph = 0;
  always @(posedge scl)
    if (ph inside {[1:4]})
      if (bitn < 8)
      begin
        sh   = {sh[6:0], sda};
        bitn = bitn + 1;
      end
      else
      begin
        mack = ~sda;
        bitn = 9;
      end
  // moves only just after scl falls, so it never makes start or stop
  always @(negedge scl)
    if (ph == 4 && bitn < 8)
      sda_oe = ~tx[7 - bitn];
    else if (ph == 4 && bitn == 8)
      sda_oe = 1'b0;
    else if (ph inside {[1:3]} && bitn == 8)
    begin
      sda_oe = !(ph == 3 && nack_data);
      if (ph == 3 && sda_oe)
        wlog.push_back(sh);
      if (ph == 2)
      begin
        last_sub = sh;
        ptr      = sh[6:3];
        ph       = 3;
      end
      if (ph == 1)
        ph = (sh[7:1] != own[7:1]) ? 5 : (sh[0] ? 4 : 2);
      sda_oe = sda_oe && ph != 5;
    end
    else if (ph inside {[1:4]} && bitn == 9)
    begin
      sda_oe = 1'b0;
      bitn   = 0;
      if (ph == 4 && !mack)
        ph = 5;
      else if (ph == 4)
      begin
        tx     = mem[ptr];
        ptr    = ptr + 4'h1;
        sda_oe = ~tx[7];
      end
    end
endmodule : i2cm_slave

// ### tb/i2cm_top_test.sv
// Purpose : self-checking bench for the i2c register master
// Assumes : short quarter period keeps the run brief
// Notes   : the slave model stands on the far side of the bus
`timescale 1ns/10ps
module i2cm_top_test;
  // ********************
  // bench
  // ********************
  localparam int QTR = 4;
  logic                    sys_clk, rst_n, cmd_valid, wr_valid, nack_data;
  logic [1:0]              up, lo, m_up, m_lo;
  logic [7:0]              wr_data, rd_data;
  logic                    cmd_ready, wr_ready, rd_valid, done;
  logic                    nack_err, busy, s_sda_oe;
  i2cm_pkg::i2cm_cmd_t     cmd;
  i2cm_pkg::i2cm_pin_in_t  pin_i;
  i2cm_pkg::i2cm_pin_out_t pin_o;
  logic [7:0]              wq [8];
  logic [7:0]              rq [$];
  int                      mismatches, compares;
  assign pin_i.scl_i = ~pin_o.scl_oe;
  assign pin_i.sda_i = ~(pin_o.sda_oe | s_sda_oe);
  always #4 sys_clk = ~sys_clk;
  i2cm_top #(.QTR(QTR)) i_i2cm_top (.sys_clk(sys_clk), .rst_n(rst_n),
    .addr_strap_upper(up), .addr_strap_lower(lo), .cmd(cmd),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .done(done), .nack_err(nack_err), .busy(busy),
    .pin_i(pin_i), .pin_o(pin_o));
  i2cm_slave i_i2cm_slave (.scl(pin_i.scl_i), .sda(pin_i.sda_i),
    .strap_up(m_up), .strap_lo(m_lo), .nack_data(nack_data),
    .sda_oe(s_sda_oe));
  function automatic logic [7:0] exp_mem(input int j);
    return 8'(j * 37) ^ 8'hc5;
  endfunction : exp_mem
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check8
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // outputs are read at the falling edge, inputs move at the rising one
  task automatic run_cmd(input logic rd, input logic [3:0] r, input int n);
    int   i;
    logic tc, tw;
    i = 0;
    rq.delete();
    @(posedge sys_clk);
    cmd <= '{read: rd, reg_sel: r, count: 8'(n)};
    cmd_valid <= 1'b1;
    wr_data <= wq[0];
    wr_valid <= !rd && n > 0;
    for (int k = 0; k < 20000; k++)
    begin
      @(negedge sys_clk);
      if (done === 1'b1)
        return;
      if (rd_valid === 1'b1)
        rq.push_back(rd_data);
      tc = cmd_ready === 1'b1;
      tw = wr_ready === 1'b1 && wr_valid;
      @(posedge sys_clk);
      if (tc)
        cmd_valid <= 1'b0;
      if (tw)
      begin
        i = i + 1;
        wr_data <= wq[i % 8];
        wr_valid <= i < n;
      end
    end
    mismatches++;
    $display("[ERR] %0t command timed out", $time);
    stop_test;
  endtask : run_cmd
  task automatic t_write;
    int base;
    base = i_i2cm_slave.wlog.size();
    wq = '{8'h00, 8'hff, 8'h5a, 8'ha5, 8'h01, 8'h80, 8'h7e, 8'h33};
    run_cmd(1'b0, 4'hf, 7);
    check8({7'h0, nack_err}, 8'h00);
    check8(i_i2cm_slave.last_sub, 8'h78);
    check8(8'(i_i2cm_slave.wlog.size() - base), 8'h07);
    for (int i = 0; i < 7; i++)
      check8(i_i2cm_slave.wlog[base + i], wq[i]);
    run_cmd(1'b0, 4'h3, 0);
    check8(i_i2cm_slave.last_sub, 8'h18);
    check8(8'(i_i2cm_slave.wlog.size() - base), 8'h07);
    $display("test write done");
  endtask : t_write
  task automatic t_read;
    for (int s = 0; s < 16; s++)
      i_i2cm_slave.mem[s] = exp_mem(s);
    for (int s = 0; s < 16; s++)
    begin
      @(posedge sys_clk);
      {up, lo} <= 4'(s);
      {m_up, m_lo} <= 4'(s);
      run_cmd(1'b1, 4'(s), 2);
      check8({7'h0, nack_err}, 8'h00);
      check8(i_i2cm_slave.last_sub, {1'b0, 4'(s), 3'h0});
      check8(8'(rq.size()), 8'h02);
      check8(rq[0], exp_mem(s));
      check8(rq[1], exp_mem((s + 1) % 16));
      check8({7'h0, i_i2cm_slave.mack}, 8'h00);
    end
    $display("test read done");
  endtask : t_read
  task automatic t_refuse(input logic [1:0] du, input logic nk);
    int base;
    base = i_i2cm_slave.wlog.size();
    @(posedge sys_clk);
    {up, lo} <= {du, 2'h0};
    {m_up, m_lo} <= 4'h0;
    nack_data <= nk;
    run_cmd(1'b0, 4'h4, 3);
    check8({7'h0, nack_err}, 8'h01);
    check8(8'(i_i2cm_slave.wlog.size() - base), 8'h00);
    @(posedge sys_clk);
    nack_data <= 1'b0;
    $display("test refuse done");
  endtask : t_refuse
  initial
  begin
    {sys_clk, rst_n, cmd_valid, wr_valid, nack_data} = 5'h00;
    {up, lo, m_up, m_lo, wr_data} = 16'h0000;
    cmd = '0;
    {mismatches, compares} = 64'h0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_write;
    t_read;
    t_refuse(2'h1, 1'b0);
    t_refuse(2'h0, 1'b1);
    t_write;
    stop_test;
  end
endmodule : i2cm_top_test
bind i2cm_top i2cm_checker #(.QTR(QTR)) i_i2cm_checker (
  .sys_clk(sys_clk), .rst_n(rst_n), .cmd(cmd), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .busy(busy), .done(done), .nack_err(nack_err),
  .rd_valid(rd_valid), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .pin_o(pin_o));
